// ==== hdl/iapm_pkg.sv ====
// package: offsets, field positions and timing for auto power management
package iapm_pkg;
    // floppy register offsets (address bits 2:0)
    localparam logic [2:0] OFS_STATUS_A   = 3'h0;
    localparam logic [2:0] OFS_STATUS_B   = 3'h1;
    localparam logic [2:0] OFS_DRIVE_MOTOR = 3'h2;
    localparam logic [2:0] OFS_RATE_MAIN  = 3'h4;
    localparam logic [2:0] OFS_DATA_FIFO  = 3'h5;
    localparam logic [2:0] OFS_INPUT_RATE = 3'h7;
    // drive_motor_control_reg fields
    localparam int DMC_RESET_N_BIT = 2;
    localparam int DMC_MOTOR_LO    = 4;
    localparam int DMC_MOTOR_W     = 4;
    // rate_select_reg fields
    localparam int RSR_SWRESET_BIT = 7;
    localparam int RSR_PWRDN_BIT   = 6;
    // auto_power_enable_cfg fields
    localparam int APE_FLOPPY_BIT  = 0;
    localparam int APE_PAR_BIT     = 3;
    localparam int APE_SER1_BIT    = 4;
    localparam int APE_SER2_BIT    = 5;
    // idle main status value
    localparam logic [7:0] MAIN_STATUS_IDLE = 8'h80;
    // extended port control mode field encodings
    localparam logic [2:0] ECR_SPP   = 3'h0;
    localparam logic [2:0] ECR_BIDIR = 3'h1;
    localparam logic [2:0] ECR_EPP   = 3'h4;
    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int AUTO_PD_TIME_MS = 10;
    localparam int AUTO_PD_CYCLES  = CLK_HZ / 1000 * AUTO_PD_TIME_MS;
    localparam int NUM_SERIAL      = 2;
endpackage : iapm_pkg

// ==== hdl/iapm_power_ctrl.sv ====
// auto power management controller for floppy, serial and parallel units
//
// Overview of operation
// RULE1 - rate select powerdown overrides auto; auto resumes after wake
// RULE2 - hardware or software reset wakes floppy and runs full reset sequence
// RULE3 - register access wake keeps all floppy state intact
// RULE4 - writing a motor enable bit wakes floppy; reading it does not
// RULE5 - reading main status wakes floppy
// RULE6 - any read or write of data fifo wakes floppy
// RULE7 - after wake restart 10 ms timer; sleep again when conditions hold
// RULE8 - non-waking accesses keep powerdown; reads true, writes stored
// RULE9 - plain motor or rate writes do not wake; enable or reset bits do
// RULE10 - non-waking access briefly activates logic, then low power again
// RULE11 - motor, select, write pulse, write gate tristated; others stay active
// RULE12 - host pins keep working; interrupt and dma request held low
// RULE13 - serial auto powerdown only when enable bits 4 and 5 set
// RULE14 - transmitter powers down when holding buffer and shifter empty
// RULE15 - receiver powers down when fifo empty and waiting for start bit
// RULE16 - phone line alert interrupt logic keeps working in powerdown
// RULE17 - transmitter wakes on host write to holding buffer
// RULE18 - receiver wakes on any level change of receive line
// RULE19 - parallel auto powerdown only when enable bit 3 set
// RULE20 - epp off when disabled or ecp mode not selecting epp
// RULE21 - ecp off when disabled or mode field selects spp, bidir or epp
// RULE22 - parallel powerdown re-evaluated whenever mode field or config changes
// RULE23 - floppy down only: motors off, status 80h, no irq, head off, timer
// RULE24 - clearing floppy enable cancels timer and holds unit awake
// RULE25 - each powerdown state is a reset-cleared flip-flop; all start powered up
`timescale 1ns/1ps
module iapm_power_ctrl
    import iapm_pkg::*;
#(
    parameter int PD_CYCLES = AUTO_PD_CYCLES,
    parameter int NSER      = NUM_SERIAL
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // host register strobes, qualified by floppy chip select
    input  wire logic              host_rd_stb,
    input  wire logic              host_wr_stb,
    input  wire logic [2:0]        host_addr,
    input  wire logic [7:0]        host_wdata,
    // configuration
    input  wire logic [7:0]        auto_power_enable_cfg,
    // floppy core status
    input  wire logic [7:0]        main_status_reg,
    input  wire logic              fdc_irq_pending,
    input  wire logic              head_unload_expired,
    input  wire logic              fdc_irq_in,
    input  wire logic              fdc_drq_in,
    // floppy drive outputs from core
    input  wire logic [3:0]        motor_on_core,
    input  wire logic [3:0]        drive_select_core,
    input  wire logic              write_pulse_core,
    input  wire logic              write_gate_core,
    // serial port status
    input  wire logic [NSER-1:0]   tx_holding_empty,
    input  wire logic [NSER-1:0]   tx_shift_empty,
    input  wire logic [NSER-1:0]   rx_fifo_empty,
    input  wire logic [NSER-1:0]   rx_idle,
    input  wire logic [NSER-1:0]   tx_hold_wr,
    input  wire logic [NSER-1:0]   serial_receive_line,
    input  wire logic [NSER-1:0]   phone_line_alert_input,
    // parallel port configuration
    input  wire logic              cfg_epp_enable,
    input  wire logic              cfg_ecp_enable,
    input  wire logic [2:0]        ecr_mode,
    // outputs
    output logic                   fdc_powered_down,
    output logic                   fdc_reset_pulse,
    output logic [7:0]             drive_motor_control_reg,
    output logic [7:0]             rate_select_reg,
    output logic [7:0]             rate_config_reg,
    output logic [3:0]             motor_on_outputs,
    output logic [3:0]             motor_on_oe_n,
    output logic [3:0]             drive_select_outputs,
    output logic [3:0]             drive_select_oe_n,
    output logic                   write_pulse_out,
    output logic                   write_pulse_oe_n,
    output logic                   write_gate_out,
    output logic                   write_gate_oe_n,
    output logic                   fdc_irq_out,
    output logic                   fdc_drq_out,
    output logic                   host_access_active,
    output logic [NSER-1:0]        tx_powered_down,
    output logic [NSER-1:0]        rx_powered_down,
    output logic [NSER-1:0]        phone_alert_sync,
    output logic                   epp_powered_down,
    output logic                   ecp_powered_down
);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic                 auto_pd;
        logic                 direct_pd;
        logic [31:0]          timer;
        logic [7:0]           dmc;
        logic [7:0]           rsr;
        logic [7:0]           rcr;
        logic                 rst_pulse;
        logic                 access;
        logic [NSER-1:0]      tx_pd;
        logic [NSER-1:0]      rx_pd;
        logic [NSER-1:0]      rxd_s1;
        logic [NSER-1:0]      rxd_s2;
        logic [NSER-1:0]      rxd_s3;
        logic [NSER-1:0]      ri_s1;
        logic [NSER-1:0]      ri_s2;
        logic                 epp_pd;
        logic                 ecp_pd;
    } iapm_state_t;

    iapm_state_t st_r;
    iapm_state_t st_nxt;

    logic       ape_floppy;
    logic       wr_dmc;
    logic       wr_rsr;
    logic       wake_access;
    logic       soft_reset;
    logic       fdc_idle;
    logic [1:0] ser_en;
    logic       par_en;

    // decode of one register offset against a strobe
    function automatic logic hit(input logic stb, input logic [2:0] a,
                                 input logic [2:0] ofs);
        hit = stb && (a == ofs);
    endfunction : hit

    // ******************************************************
    // floppy wake and entry conditions
    // ******************************************************
    always_comb begin
        ape_floppy = auto_power_enable_cfg[APE_FLOPPY_BIT];
        wr_dmc     = hit(host_wr_stb, host_addr, OFS_DRIVE_MOTOR);
        wr_rsr     = hit(host_wr_stb, host_addr, OFS_RATE_MAIN);
        // software reset: motor control reset bit low, or rate select reset bit high
        soft_reset = (wr_dmc && !host_wdata[DMC_RESET_N_BIT])
                   || (wr_rsr && host_wdata[RSR_SWRESET_BIT]); // [RULE2]
        wake_access =
            (wr_dmc && (|host_wdata[DMC_MOTOR_LO +: DMC_MOTOR_W])) // [RULE4]
            || hit(host_rd_stb, host_addr, OFS_RATE_MAIN)        // [RULE5]
            || hit(host_rd_stb, host_addr, OFS_DATA_FIFO)        // [RULE6]
            || hit(host_wr_stb, host_addr, OFS_DATA_FIFO)        // [RULE6]
            || soft_reset;                                       // [RULE9]

        // all four entry conditions, timer checked separately
        fdc_idle = (st_r.dmc[DMC_MOTOR_LO +: DMC_MOTOR_W] == '0)
                 && (main_status_reg == MAIN_STATUS_IDLE)
                 && !fdc_irq_pending && head_unload_expired;   // [RULE23]
        ser_en = {auto_power_enable_cfg[APE_SER2_BIT],
                  auto_power_enable_cfg[APE_SER1_BIT]};          // [RULE13]
        par_en = auto_power_enable_cfg[APE_PAR_BIT];             // [RULE19]
    end

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rst_pulse = soft_reset;
        // strobes briefly wake logic; it drops once the strobe is gone
        st_nxt.access = host_rd_stb || host_wr_stb;              // [RULE10]

        // writes land in the shadow registers even while asleep
        if (wr_dmc) begin
            st_nxt.dmc = host_wdata;                             // [RULE8]
        end
        if (wr_rsr) begin
            st_nxt.rsr = host_wdata;                             // [RULE8]
            st_nxt.direct_pd = host_wdata[RSR_PWRDN_BIT];        // [RULE1]
        end
        if (hit(host_wr_stb, host_addr, OFS_INPUT_RATE)) begin
            st_nxt.rcr = host_wdata;                             // [RULE8]
        end
        if (soft_reset) begin
            st_nxt.direct_pd = 1'b0;
        end

        // floppy auto powerdown timer and state
        if (!ape_floppy) begin
            st_nxt.timer   = '0;                                 // [RULE24]
            st_nxt.auto_pd = 1'b0;                               // [RULE24]
        end else if (wake_access || st_r.direct_pd) begin
            // wake keeps core state; timer starts a fresh period
            st_nxt.timer   = '0;                                 // [RULE7]
            st_nxt.auto_pd = 1'b0;                               // [RULE3]
        end else if (!st_r.auto_pd) begin
            if (st_r.timer < 32'(PD_CYCLES - 1)) begin
                st_nxt.timer = st_r.timer + 32'd1;               // [RULE7]
            end else if (fdc_idle) begin
                st_nxt.auto_pd = 1'b1;                           // [RULE23]
            end
        end

        // serial ports: synchronise receive line and alert input
        st_nxt.rxd_s1 = serial_receive_line;
        st_nxt.rxd_s2 = st_r.rxd_s1;
        st_nxt.rxd_s3 = st_r.rxd_s2;
        st_nxt.ri_s1  = phone_line_alert_input;
        st_nxt.ri_s2  = st_r.ri_s1;                              // [RULE16]
        for (int i = 0; i < NSER; i++) begin
            if (!ser_en[i] || tx_hold_wr[i]) begin
                st_nxt.tx_pd[i] = 1'b0;                          // [RULE17]
            end else begin
                st_nxt.tx_pd[i] = tx_holding_empty[i]
                                && tx_shift_empty[i];            // [RULE14]
            end
            if (!ser_en[i] || (st_r.rxd_s2[i] != st_r.rxd_s3[i])) begin
                st_nxt.rx_pd[i] = 1'b0;                          // [RULE18]
            end else if (rx_fifo_empty[i] && rx_idle[i]) begin
                st_nxt.rx_pd[i] = 1'b1;                          // [RULE15]
            end else begin
                st_nxt.rx_pd[i] = 1'b0;
            end
        end

        // parallel port, evaluated every cycle so mode changes apply on the next clock
        st_nxt.epp_pd = par_en && (!cfg_epp_enable
                      || (cfg_ecp_enable && ecr_mode != ECR_EPP)); // [RULE20]
        st_nxt.ecp_pd = par_en && (!cfg_ecp_enable
                      || ecr_mode == ECR_SPP || ecr_mode == ECR_BIDIR
                      || ecr_mode == ECR_EPP);                   // [RULE21] [RULE22]
    end

    // ******************************************************
    // state register, all units powered up after reset
    // ******************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;                                          // [RULE25] [RULE2]
            // receive lines idle high; a zero here would fake an edge
            st_r.rxd_s1 <= '1;
            st_r.rxd_s2 <= '1;
            st_r.rxd_s3 <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ******************************************************
    // outputs and pin gating
    // ******************************************************
    always_comb begin
        // direct powerdown overrides auto state while it is set
        fdc_powered_down = st_r.direct_pd || st_r.auto_pd;       // [RULE1]
        fdc_reset_pulse  = st_r.rst_pulse;
        drive_motor_control_reg = st_r.dmc;
        rate_select_reg  = st_r.rsr;
        rate_config_reg  = st_r.rcr;
        host_access_active = st_r.access;
        motor_on_outputs = motor_on_core;
        drive_select_outputs = drive_select_core;
        write_pulse_out  = write_pulse_core;
        write_gate_out   = write_gate_core;

        // drive-facing pins float so no current flows into a dead drive
        motor_on_oe_n    = {4{st_r.auto_pd}};                    // [RULE11]
        drive_select_oe_n = {4{st_r.auto_pd}};                   // [RULE11]
        write_pulse_oe_n = st_r.auto_pd;                         // [RULE11]
        write_gate_oe_n  = st_r.auto_pd;                         // [RULE11]

        fdc_irq_out = fdc_irq_in && !st_r.auto_pd;               // [RULE12]
        fdc_drq_out = fdc_drq_in && !st_r.auto_pd;               // [RULE12]

        tx_powered_down  = st_r.tx_pd;
        rx_powered_down  = st_r.rx_pd;
        phone_alert_sync = st_r.ri_s2;                           // [RULE16]
        epp_powered_down = st_r.epp_pd;
        ecp_powered_down = st_r.ecp_pd;
    end

    // ******************************************************
    // checks
    // ******************************************************
    property p_cfg_off_awake;
        @(posedge sys_clk) disable iff (reset)
        !ape_floppy |=> !st_r.auto_pd;
    endproperty
    a_cfg_off_awake: assert property (p_cfg_off_awake) // [RULE24]
        else $error("auto powerdown while disabled");

    property p_data_wake;
        @(posedge sys_clk) disable iff (reset)
        (hit(host_rd_stb, host_addr, OFS_DATA_FIFO)
         || hit(host_wr_stb, host_addr, OFS_DATA_FIFO)) |=> !st_r.auto_pd;
    endproperty
    a_data_wake: assert property (p_data_wake) // [RULE6]
        else $error("data fifo access did not wake");

    property p_status_wake;
        @(posedge sys_clk) disable iff (reset)
        hit(host_rd_stb, host_addr, OFS_RATE_MAIN) |=> !st_r.auto_pd;
    endproperty
    a_status_wake: assert property (p_status_wake) // [RULE5]
        else $error("main status read did not wake");

    property p_dmc_read_sleep;
        @(posedge sys_clk) disable iff (reset)
        (st_r.auto_pd && ape_floppy && !st_r.direct_pd
         && hit(host_rd_stb, host_addr, OFS_DRIVE_MOTOR)
         && !host_wr_stb) |=> st_r.auto_pd;
    endproperty
    a_dmc_read_sleep: assert property (p_dmc_read_sleep) // [RULE4]
        else $error("motor control read woke unit");

    property p_wake_timer;
        @(posedge sys_clk) disable iff (reset)
        (ape_floppy && wake_access) |=> (st_r.timer == 32'd0);
    endproperty
    a_wake_timer: assert property (p_wake_timer) // [RULE7]
        else $error("timer not restarted on wake");

    property p_entry_needs_idle;
        @(posedge sys_clk) disable iff (reset)
        $rose(st_r.auto_pd) |-> $past(fdc_idle)
            && ($past(st_r.timer) == 32'(PD_CYCLES - 1));
    endproperty
    a_entry_needs_idle: assert property (p_entry_needs_idle) // [RULE23]
        else $error("powerdown entered without conditions");

    property p_pins_float;
        @(posedge sys_clk) disable iff (reset)
        st_r.auto_pd |-> (motor_on_oe_n == 4'hF) && write_gate_oe_n
            && !fdc_irq_out && !fdc_drq_out;
    endproperty
    a_pins_float: assert property (p_pins_float) // [RULE11] [RULE12]
        else $error("pins active in powerdown");

    property p_tx_wake;
        @(posedge sys_clk) disable iff (reset)
        tx_hold_wr[0] |=> !tx_powered_down[0];
    endproperty
    a_tx_wake: assert property (p_tx_wake) // [RULE17]
        else $error("transmitter did not wake");

    property p_rx_edge_wake;
        @(posedge sys_clk) disable iff (reset)
        (serial_receive_line[0] != $past(serial_receive_line[0]))
            |-> ##3 !rx_powered_down[0];
    endproperty
    a_rx_edge_wake: assert property (p_rx_edge_wake) // [RULE18]
        else $error("receiver missed line change");

    property p_par_gate;
        @(posedge sys_clk) disable iff (reset)
        !par_en |=> !epp_powered_down && !ecp_powered_down;
    endproperty
    a_par_gate: assert property (p_par_gate) // [RULE19]
        else $error("parallel powerdown while disabled");

    property p_soft_wake;
        @(posedge sys_clk) disable iff (reset)
        soft_reset |=> fdc_reset_pulse && !fdc_powered_down;
    endproperty
    a_soft_wake: assert property (p_soft_wake) // [RULE2]
        else $error("soft reset did not wake");

    property p_motor_wake;
        @(posedge sys_clk) disable iff (reset)
        (wr_dmc && |host_wdata[DMC_MOTOR_LO +: DMC_MOTOR_W]) |=> !st_r.auto_pd;
    endproperty
    a_motor_wake: assert property (p_motor_wake) // [RULE4]
        else $error("motor enable write did not wake");

    property p_access_brief;
        @(posedge sys_clk) disable iff (reset)
        !(host_rd_stb || host_wr_stb) |=> !host_access_active;
    endproperty
    a_access_brief: assert property (p_access_brief) // [RULE10]
        else $error("access activity outlived the strobe");

endmodule : iapm_power_ctrl

// ==== verification/iapm_core_model.sv ====
// behavioural floppy core and drive side facing the power controller
`timescale 1ns/1ps
module iapm_core_model
    import iapm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       busy,
    input  wire logic [7:0] dmc,
    output logic [7:0]      main_status_reg,
    output logic            head_unload_expired,
    output logic [3:0]      motor_on_core,
    output logic [3:0]      drive_select_core,
    output logic            write_pulse_core,
    output logic            write_gate_core
);
    logic [3:0] hut_r;
    // head stays loaded for a while after the motors stop
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hut_r <= 4'h0;
        end else if (dmc[7:4] != 4'h0) begin
            hut_r <= 4'h0;
        end else if (hut_r != 4'hf) begin
            hut_r <= hut_r + 4'h1;
        end
    end
    // write data toggles each cycle, so a stale level never passes
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            write_pulse_core <= 1'b0;
        end else begin
            write_pulse_core <= ~write_pulse_core;
        end
    end
    // status reads idle unless a command is in flight
    assign main_status_reg     = busy ? 8'h90 : MAIN_STATUS_IDLE;
    assign head_unload_expired = (hut_r == 4'hf);
    assign motor_on_core       = dmc[7:4];
    assign drive_select_core   = 4'h1 << dmc[1:0];
    assign write_gate_core     = busy;
endmodule : iapm_core_model

// ==== verification/io_auto_power_management_tb_top.sv ====
// self-checking bench for the auto power management controller
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module io_auto_power_management_tb_top;
    import iapm_pkg::*;
    localparam int PD = 20;  // short idle count keeps the run brief
    logic sys_clk = 1'b0, reset = 1'b1, busy = 1'b0;
    logic host_rd_stb = 1'b0, host_wr_stb = 1'b0, fdc_irq_pending = 1'b0;
    logic [2:0] host_addr = 3'h0, ecr_mode = 3'h0;
    logic [7:0] host_wdata = 8'h00, auto_power_enable_cfg = 8'h00;
    logic fdc_irq_in = 1'b1, fdc_drq_in = 1'b1;
    logic cfg_epp_enable = 1'b0, cfg_ecp_enable = 1'b0;
    logic [1:0] tx_holding_empty = 2'h3, tx_shift_empty = 2'h3;
    logic [1:0] rx_fifo_empty = 2'h3, rx_idle = 2'h3, tx_hold_wr = 2'h0;
    logic [1:0] serial_receive_line = 2'h3, phone_line_alert_input = 2'h0;
    logic [7:0] main_status_reg, drive_motor_control_reg, rate_select_reg;
    logic [7:0] rate_config_reg, rsr, rcf;
    logic [3:0] motor_on_core, drive_select_core, motor_on_outputs;
    logic [3:0] motor_on_oe_n, drive_select_outputs, drive_select_oe_n;
    logic head_unload_expired, write_pulse_core, write_gate_core, seen;
    logic fdc_powered_down, fdc_reset_pulse, write_pulse_out;
    logic write_pulse_oe_n, write_gate_out, write_gate_oe_n, fdc_irq_out;
    logic fdc_drq_out, host_access_active, epp_powered_down;
    logic ecp_powered_down;
    logic [1:0] tx_powered_down, rx_powered_down, phone_alert_sync;
    logic [5:0] exp_pd;
    logic [16:0] wk [4] = '{17'h0_0400, 17'h0_0500, 17'h1_0500, 17'h1_02f4};
    int mismatches = 0, n_tests = 0, k;

    always #10 sys_clk = ~sys_clk;

    iapm_power_ctrl #(.PD_CYCLES(PD), .NSER(2)) i_dut (.*);
    iapm_core_model i_core (.sys_clk, .reset, .busy,
        .dmc(drive_motor_control_reg), .main_status_reg,
        .head_unload_expired, .motor_on_core, .drive_select_core,
        .write_pulse_core, .write_gate_core);

    // ****************************************************************
    // expectations and bus tasks
    // ****************************************************************
    function automatic logic [5:0] f_exp(logic [7:0] c, logic pe, pc,
                                         logic [2:0] m);
        logic [1:0] tx, rx;
        logic       ep, ec;
        tx = c[APE_SER2_BIT:APE_SER1_BIT] & tx_holding_empty & tx_shift_empty;
        rx = c[APE_SER2_BIT:APE_SER1_BIT] & rx_fifo_empty & rx_idle;
        ep = c[APE_PAR_BIT] & (!pe | (pc & (m != ECR_EPP)));
        ec = c[APE_PAR_BIT] & (!pc | m == ECR_SPP | m == ECR_BIDIR |
                               m == ECR_EPP);
        return {ep, ec, tx, rx};
    endfunction : f_exp

    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // one access; returns just after the edge that takes it
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        host_rd_stb <= ~w;
        host_wr_stb <= w;
        host_addr   <= a;
        host_wdata  <= d;
        @(posedge sys_clk);
        host_rd_stb <= 1'b0;
        host_wr_stb <= 1'b0;
        #1;
    endtask : acc

    // bounded wait for the floppy powerdown level
    task automatic wait_pd(input logic v);
        for (int i = 0; i < 3 * PD && fdc_powered_down !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (fdc_powered_down !== v) begin
            mismatches++;
            final_report();
        end
    endtask : wait_pd

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(48));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        `CHK({fdc_powered_down, motor_on_oe_n}, 5'h00)
        acc(1'b1, OFS_DRIVE_MOTOR, 8'h04);
        // busy core or pending interrupt keeps the unit awake
        for (k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            busy <= (k == 0);
            fdc_irq_pending <= (k == 1);
            auto_power_enable_cfg <= 8'h01;
            repeat (3 * PD) @(posedge sys_clk);
            #1;
            `CHK(fdc_powered_down, 1'b0)
        end
        @(posedge sys_clk);
        fdc_irq_pending <= 1'b0;
        wait_pd(1'b1);
        `CHK({motor_on_oe_n, drive_select_oe_n}, 8'hff)
        `CHK({write_pulse_oe_n, write_gate_oe_n}, 2'h3)
        `CHK({fdc_irq_out, fdc_drq_out}, 2'h0)
        `CHK({motor_on_outputs, drive_select_outputs}, 8'h01)
        `CHK(write_pulse_out, write_pulse_core)
        `CHK(write_gate_out, write_gate_core)
        // accesses that must leave the unit asleep, writes kept
        rcf = 8'($urandom);
        rsr = 8'($urandom) & 8'h3f;
        for (k = 0; k < 4; k++) acc(1'b0, 3'(k == 3 ? 7 : k), 8'h00);
        acc(1'b1, OFS_INPUT_RATE, rcf);
        acc(1'b1, OFS_DRIVE_MOTOR, 8'h0c);
        acc(1'b1, OFS_RATE_MAIN, rsr);
        `CHK(host_access_active, 1'b1)
        @(posedge sys_clk);
        #1;
        `CHK(fdc_powered_down, 1'b1)
        `CHK(host_access_active, 1'b0)
        `CHK({rate_config_reg, rate_select_reg}, {rcf, rsr})
        `CHK(drive_motor_control_reg, 8'h0c)
        // each waking access, then the timer starts over
        for (k = 0; k < 4; k++) begin
            wait_pd(1'b1);
            acc(wk[k][16], wk[k][10:8], wk[k][7:0]);
            @(posedge sys_clk);
            #1;
            `CHK({fdc_powered_down, fdc_reset_pulse}, 2'h0)
            repeat (PD / 2) @(posedge sys_clk);
            #1;
            `CHK(fdc_powered_down, 1'b0)
        end
        acc(1'b1, OFS_DRIVE_MOTOR, 8'h04);
        // direct powerdown over auto, soft reset wakes, auto returns
        wait_pd(1'b1);
        acc(1'b1, OFS_RATE_MAIN, 8'h40);
        repeat (PD * 3) @(posedge sys_clk);
        #1;
        `CHK(fdc_powered_down, 1'b1)
        acc(1'b1, OFS_RATE_MAIN, 8'h80);
        `CHK(fdc_reset_pulse, 1'b1)
        @(posedge sys_clk);
        #1;
        `CHK(fdc_powered_down, 1'b0)
        wait_pd(1'b1);
        acc(1'b1, OFS_DRIVE_MOTOR, 8'h00);
        `CHK(fdc_reset_pulse, 1'b1)
        acc(1'b1, OFS_DRIVE_MOTOR, 8'h04);
        `CHK(fdc_powered_down, 1'b0)
        // clearing the enable mid-count restarts the wait
        @(posedge sys_clk);
        repeat (PD / 2) @(posedge sys_clk);
        auto_power_enable_cfg <= 8'h00;
        @(posedge sys_clk);
        auto_power_enable_cfg <= 8'h01;
        repeat (PD / 2 + 2) @(posedge sys_clk);
        #1;
        `CHK(fdc_powered_down, 1'b0)
        // serial and parallel levels across random settings
        for (k = 0; k < 24; k++) begin
            @(posedge sys_clk);
            auto_power_enable_cfg <= {2'h0, 2'($urandom), 1'($urandom),
                                      3'h0};
            {tx_holding_empty, tx_shift_empty} <= 4'($urandom);
            {rx_fifo_empty, rx_idle} <= 4'($urandom);
            {cfg_epp_enable, cfg_ecp_enable, ecr_mode} <= 5'($urandom);
            phone_line_alert_input <= 2'($urandom);
            repeat (4) @(posedge sys_clk);
            #1;
            exp_pd = f_exp(auto_power_enable_cfg, cfg_epp_enable,
                           cfg_ecp_enable, ecr_mode);
            `CHK(tx_powered_down, exp_pd[3:2])
            `CHK(rx_powered_down, exp_pd[1:0])
            `CHK(epp_powered_down, exp_pd[5])
            `CHK(ecp_powered_down, exp_pd[4])
            `CHK(phone_alert_sync, phone_line_alert_input)
        end
        // holding buffer write and receive line edge wake the port
        @(posedge sys_clk);
        auto_power_enable_cfg <= 8'h31;
        {tx_holding_empty, tx_shift_empty, rx_fifo_empty, rx_idle} <= '1;
        repeat (4) @(posedge sys_clk);
        tx_hold_wr <= 2'h1;
        tx_holding_empty <= 2'h2;
        serial_receive_line <= 2'h2;
        @(posedge sys_clk);
        tx_hold_wr <= 2'h0;
        seen = 1'b0;
        repeat (6) begin
            @(posedge sys_clk);
            #1;
            seen = seen | (rx_powered_down[0] === 1'b0);
        end
        `CHK({seen, tx_powered_down}, 3'h6)
        // hardware reset in mid-run while asleep
        wait_pd(1'b1);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK({fdc_powered_down, motor_on_oe_n}, 5'h00)
        @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK({fdc_powered_down, drive_motor_control_reg}, 9'h000)
        final_report();
    end
endmodule : io_auto_power_management_tb_top
